// File: src/mif_metering_irq_flags.sv
// Overview of operation
// - Summary bit 7 of sign register follows, one cycle later, whether any enabled flag is set.
// - Fault mode change in the configured direction sets sign register bit 5.
// - Reactive power sign change in configured direction sets sign register bit 4.
// - Active power sign change in configured direction sets sign register bit 3.
// - Apparent no-load or current-rms no-load entry sets sign register bit 2.
// - Reactive no-load detection sets sign register bit 1.
// - Active no-load detection sets sign register bit 0.
// - Every second frequency pulse sets pulse register bit 7, output enabled or not.
// - Every first frequency pulse sets pulse register bit 6, output enabled or not.
// - Apparent, reactive, active energy overflow set pulse register bits 5, 4, 3.
// - Apparent, reactive, active energy half full set pulse register bits 2, 1, 0.
// - End of hardware or software reset sets line register bit 7.
// - New waveform samples set line register bit 5.
// - Current above its peak threshold sets line register bit 4.
// - Voltage above its peak threshold sets line register bit 3.
// - End of line-cycle energy accumulation sets line register bit 2.
// - Zero crossing timeout sets line register bit 1.
// - Each voltage zero crossing sets line register bit 0.
// - Sign enable bits 5..0 let matching flags raise the interrupt; 7..6 reserved.
// - Pulse enable bits 7..0 let matching flags raise the interrupt.
// - Line enable bits 5..0 let matching flags raise the interrupt; 7..6 reserved.
// - Active sign fires positive-to-negative when direction is 0, else negative-to-positive.
`timescale 1ns/1ns
`default_nettype none
module mif_metering_irq_flags
  import mif_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic swReset,
  input wire logic activePowerNeg,
  input wire logic reactivePowerNeg,
  input wire logic faultModeAlt,
  input wire logic activeSignDir,
  input wire logic reactiveSignDir,
  input wire logic faultSignDir,
  input wire logic apparentNoLoad,
  input wire logic irmsNoLoadEntry,
  input wire logic reactiveNoLoad,
  input wire logic activeNoLoad,
  input wire logic freqPulseTwo,
  input wire logic freqPulseOne,
  input wire logic apparentEnergyOverflow,
  input wire logic reactiveEnergyOverflow,
  input wire logic activeEnergyOverflow,
  input wire logic apparentEnergyHalf,
  input wire logic reactiveEnergyHalf,
  input wire logic activeEnergyHalf,
  input wire logic waveformSampleReady,
  input wire logic currentPeakHit,
  input wire logic voltagePeakHit,
  input wire logic lineCycleDone,
  input wire logic zeroCrossTimeout,
  input wire logic zeroCrossSeen,
  output logic [7:0] sfrRdData,
  output logic sfrRdValid,
  output logic meteringIrq
);

  localparam logic [23:0] FLAG_RST = {ST_LINE_RST, ST_PULSE_RST, ST_SIGN_RST};
  localparam logic [23:0] EN_RST = {EN_LINE_RST, EN_PULSE_RST, EN_SIGN_RST};
  logic rstMeta;
  logic rstN;
  logic [SIGN_CHANNELS-1:0] signPrev;
  logic signPrimed;
  logic [23:0] flags;
  logic [23:0] enables;
  wire logic [SIGN_CHANNELS-1:0] signLevel;
  wire logic [SIGN_CHANNELS-1:0] signDir;
  wire logic [SIGN_CHANNELS-1:0] signEvent;
  wire logic [23:0] setVec;
  wire logic [23:0] clrVec;
  wire logic [23:0] flagMask;
  wire logic [23:0] flagRst;
  wire logic [23:0] enMask;
  wire logic [23:0] enRst;
  wire logic [23:0] enWrite;
  wire logic [23:0] wrData3;
  wire logic pendingAny;
  wire logic wrStSign;
  wire logic wrStPulse;
  wire logic wrStLine;
  wire logic wrEnSign;
  wire logic wrEnPulse;
  wire logic wrEnLine;
  wire logic rdHit;
  wire logic [7:0] rdMux;

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // Packed masks and reset values, sign register in the low byte
  assign flagMask = {ST_LINE_MASK, ST_PULSE_MASK, ST_SIGN_MASK};
  assign flagRst = {ST_LINE_RST, ST_PULSE_RST, ST_SIGN_RST};
  assign enMask = {EN_LINE_MASK, EN_PULSE_MASK, EN_SIGN_MASK};
  assign enRst = {EN_LINE_RST, EN_PULSE_RST, EN_SIGN_RST};
  assign wrData3 = {sfrWrData, sfrWrData, sfrWrData};

  // Register port address decode
  assign wrStSign = sfrWrEn & (sfrAddr == ADDR_ST_SIGN);
  assign wrStPulse = sfrWrEn & (sfrAddr == ADDR_ST_PULSE);
  assign wrStLine = sfrWrEn & (sfrAddr == ADDR_ST_LINE);
  assign wrEnSign = sfrWrEn & (sfrAddr == ADDR_EN_SIGN);
  assign wrEnPulse = sfrWrEn & (sfrAddr == ADDR_EN_PULSE);
  assign wrEnLine = sfrWrEn & (sfrAddr == ADDR_EN_LINE);

  // Sign change detectors: level inputs and their trigger direction
  assign signLevel = {faultModeAlt, reactivePowerNeg, activePowerNeg};
  assign signDir = {faultSignDir, reactiveSignDir, activeSignDir};

  genvar g;
  generate
    for (g = 0; g < SIGN_CHANNELS; g++) begin : gSign
      // Direction 0 catches a rise of the level, 1 catches a fall
      assign signEvent[g] = signPrimed & (signDir[g] ? (signPrev[g] & ~signLevel[g])
                                                     : (~signPrev[g] & signLevel[g]));
    end
  endgenerate

  // Previous level; first cycle after reset has no history
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      signPrev <= '0;
      signPrimed <= 1'b0;
    end else begin
      signPrev <= signLevel;
      signPrimed <= 1'b1;
    end
  end

  // Sign and no-load event sources
  assign setVec[SIGN_BASE + ACTIVE_NO_LOAD] = activeNoLoad;
  assign setVec[SIGN_BASE + REACTIVE_NO_LOAD] = reactiveNoLoad;
  assign setVec[SIGN_BASE + APPARENT_NO_LOAD] = apparentNoLoad | irmsNoLoadEntry;
  assign setVec[SIGN_BASE + ACTIVE_SIGN_CHANGE] = signEvent[0];
  assign setVec[SIGN_BASE + REACTIVE_SIGN_CHANGE] = signEvent[1];
  assign setVec[SIGN_BASE + FAULT_MODE_CHANGE] = signEvent[2];
  assign setVec[SIGN_BASE + RESERVED_BIT] = 1'b0;
  assign setVec[SIGN_BASE + METERING_IRQ_SUMMARY] = 1'b0;

  // Pulse and energy event sources; pulses count whether or not the pin drives
  assign setVec[PULSE_BASE + ACTIVE_ENERGY_HALF] = activeEnergyHalf;
  assign setVec[PULSE_BASE + REACTIVE_ENERGY_HALF] = reactiveEnergyHalf;
  assign setVec[PULSE_BASE + APPARENT_ENERGY_HALF] = apparentEnergyHalf;
  assign setVec[PULSE_BASE + ACTIVE_ENERGY_OVERFLOW] = activeEnergyOverflow;
  assign setVec[PULSE_BASE + REACTIVE_ENERGY_OVERFLOW] = reactiveEnergyOverflow;
  assign setVec[PULSE_BASE + APPARENT_ENERGY_OVERFLOW] = apparentEnergyOverflow;
  assign setVec[PULSE_BASE + FREQ_PULSE_ONE] = freqPulseOne;
  assign setVec[PULSE_BASE + FREQ_PULSE_TWO] = freqPulseTwo;

  // Line event sources; reset-done flag comes from the reset value
  assign setVec[LINE_BASE + ZERO_CROSS_SEEN] = zeroCrossSeen;
  assign setVec[LINE_BASE + ZERO_CROSS_TIMEOUT] = zeroCrossTimeout;
  assign setVec[LINE_BASE + LINE_CYCLE_DONE] = lineCycleDone;
  assign setVec[LINE_BASE + VOLTAGE_PEAK_HIT] = voltagePeakHit;
  assign setVec[LINE_BASE + CURRENT_PEAK_HIT] = currentPeakHit;
  assign setVec[LINE_BASE + WAVEFORM_SAMPLE_READY] = waveformSampleReady;
  assign setVec[LINE_BASE + RESERVED_BIT] = 1'b0;
  assign setVec[LINE_BASE + RESET_DONE] = 1'b0;

  // Writing 0 to a status bit clears it, writing 1 leaves it
  assign clrVec = {{8{wrStLine}}, {8{wrStPulse}}, {8{wrStSign}}} & ~wrData3;
  assign enWrite = {{8{wrEnLine}}, {8{wrEnPulse}}, {8{wrEnSign}}};

  // Status flags: event set wins over a clear in the same cycle
  generate
    for (g = 0; g < 24; g++) begin : gFlag
      always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
          flags[g] <= FLAG_RST[g];
        end else if (swReset) begin
          flags[g] <= flagRst[g];
        end else begin
          flags[g] <= (setVec[g] | (flags[g] & ~clrVec[g])) & flagMask[g];
        end
      end
    end
  endgenerate

  // Enable bits, reserved positions held at zero
  generate
    for (g = 0; g < 24; g++) begin : gEnable
      always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
          enables[g] <= EN_RST[g];
        end else if (swReset) begin
          enables[g] <= enRst[g];
        end else if (enWrite[g]) begin
          enables[g] <= wrData3[g] & enMask[g];
        end
      end
    end
  endgenerate

  // Any enabled pending flag
  assign pendingAny = |(flags & enables & enMask);

  // Summary flag doubles as the level interrupt request
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      meteringIrq <= 1'b0;
    end else begin
      meteringIrq <= pendingAny;
    end
  end

  // Read selection; summary replaces bit 7 of the sign register
  assign rdHit = (sfrAddr == ADDR_ST_SIGN) | (sfrAddr == ADDR_ST_PULSE) |
                 (sfrAddr == ADDR_ST_LINE) | (sfrAddr == ADDR_EN_SIGN) |
                 (sfrAddr == ADDR_EN_PULSE) | (sfrAddr == ADDR_EN_LINE);
  assign rdMux = (sfrAddr == ADDR_ST_SIGN) ? {meteringIrq, flags[6:0]} :
                 (sfrAddr == ADDR_ST_PULSE) ? flags[15:8] :
                 (sfrAddr == ADDR_ST_LINE) ? flags[23:16] :
                 (sfrAddr == ADDR_EN_SIGN) ? enables[7:0] :
                 (sfrAddr == ADDR_EN_PULSE) ? enables[15:8] :
                 (sfrAddr == ADDR_EN_LINE) ? enables[23:16] : 8'h00;

  // Registered read answer one cycle after the strobe
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      sfrRdData <= 8'h00;
      sfrRdValid <= 1'b0;
    end else begin
      sfrRdValid <= sfrRdEn & rdHit;
      if (sfrRdEn & rdHit) begin
        sfrRdData <= rdMux;
      end
    end
  end

  // Interrupt rises one cycle after an enabled flag is pending
  a_irq_rises: assert property (@(posedge mclk) disable iff (!rstN)
    pendingAny |=> meteringIrq)
    else $error("Interrupt missing after enabled pending flag");

  // Interrupt drops once nothing enabled is pending
  a_irq_drops: assert property (@(posedge mclk) disable iff (!rstN)
    !pendingAny |=> !meteringIrq)
    else $error("Interrupt held with nothing pending");

  // Masked flags never raise the interrupt
  a_mask_blocks: assert property (@(posedge mclk) disable iff (!rstN)
    ((enables & enMask) == 24'h000000) |=> !meteringIrq)
    else $error("Interrupt raised with all enables clear");

  // Active sign change in the selected direction is caught
  a_active_sign: assert property (@(posedge mclk) disable iff (!rstN)
    (signPrimed && !swReset && (activeSignDir ? ($past(activePowerNeg) && !activePowerNeg)
                                : (!$past(activePowerNeg) && activePowerNeg)))
    |=> flags[SIGN_BASE + ACTIVE_SIGN_CHANGE])
    else $error("Active sign change not flagged");

  // Active sign flag never set while the level stays high with direction 0
  a_sign_direction: assert property (@(posedge mclk) disable iff (!rstN)
    (!flags[SIGN_BASE + ACTIVE_SIGN_CHANGE] && !activeSignDir && activePowerNeg
     && $past(activePowerNeg) && !activeNoLoad)
    |=> !flags[SIGN_BASE + ACTIVE_SIGN_CHANGE])
    else $error("Active sign flag set without a change");

  // Second frequency pulse flagged unless software reset is active
  a_pulse_two: assert property (@(posedge mclk) disable iff (!rstN)
    (freqPulseTwo && !swReset) |=> flags[PULSE_BASE + FREQ_PULSE_TWO])
    else $error("Second frequency pulse not flagged");

  // First frequency pulse flagged unless software reset is active
  a_pulse_one: assert property (@(posedge mclk) disable iff (!rstN)
    (freqPulseOne && !swReset) |=> flags[PULSE_BASE + FREQ_PULSE_ONE])
    else $error("First frequency pulse not flagged");

  // Overflow reaches its own bit
  a_overflow_flag: assert property (@(posedge mclk) disable iff (!rstN)
    (apparentEnergyOverflow && !swReset) |=> flags[PULSE_BASE + APPARENT_ENERGY_OVERFLOW])
    else $error("Apparent energy overflow not flagged");

  // Half full reaches its own bit
  a_half_flag: assert property (@(posedge mclk) disable iff (!rstN)
    (reactiveEnergyHalf && !swReset) |=> flags[PULSE_BASE + REACTIVE_ENERGY_HALF])
    else $error("Reactive energy half full not flagged");

  // Software reset ends with reset-done set and enables cleared
  a_soft_reset: assert property (@(posedge mclk) disable iff (!rstN)
    swReset |=> (flags[LINE_BASE + RESET_DONE] && (enables == 24'h000000)))
    else $error("Software reset did not leave reset-done flag");

  // Waveform sample flag
  a_wave_flag: assert property (@(posedge mclk) disable iff (!rstN)
    (waveformSampleReady && !swReset) |=> flags[LINE_BASE + WAVEFORM_SAMPLE_READY])
    else $error("Waveform sample flag not set");

  // Set wins over a clear write in the same cycle
  a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rstN)
    (activeNoLoad && wrStSign && !sfrWrData[0] && !swReset)
    |=> flags[SIGN_BASE + ACTIVE_NO_LOAD])
    else $error("Clear write lost a simultaneous event");

  // Flags stick until a clearing write or software reset
  a_flag_sticky: assert property (@(posedge mclk) disable iff (!rstN)
    (flags[LINE_BASE + ZERO_CROSS_SEEN] && !(wrStLine && !sfrWrData[0]) && !swReset)
    |=> flags[LINE_BASE + ZERO_CROSS_SEEN])
    else $error("Zero crossing flag dropped without a clear");

  // Clearing write drops an idle flag
  a_clear_works: assert property (@(posedge mclk) disable iff (!rstN)
    (wrStLine && !sfrWrData[0] && !zeroCrossSeen && !swReset)
    |=> !flags[LINE_BASE + ZERO_CROSS_SEEN])
    else $error("Clearing write left zero crossing flag set");

  // Reserved bit 6 reads zero outside the pulse registers
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstN)
    (sfrRdEn && rdHit && (sfrAddr != ADDR_ST_PULSE) && (sfrAddr != ADDR_EN_PULSE))
    |=> (sfrRdValid && !sfrRdData[6]))
    else $error("Reserved bit read as one");

  // Summary bit read matches the interrupt level
  a_summary_read: assert property (@(posedge mclk) disable iff (!rstN)
    (sfrRdEn && (sfrAddr == ADDR_ST_SIGN)) |=> (sfrRdData[7] == $past(meteringIrq)))
    else $error("Summary bit differs from interrupt request");

  // Fault mode change in the selected direction is caught
  a_fault_sign: assert property (@(posedge mclk) disable iff (!rstN)
    (signPrimed && !swReset && (faultSignDir ? ($past(faultModeAlt) && !faultModeAlt)
                                : (!$past(faultModeAlt) && faultModeAlt)))
    |=> flags[SIGN_BASE + FAULT_MODE_CHANGE])
    else $error("Fault mode change not flagged");

  // Reactive sign change in the selected direction is caught
  a_reactive_sign: assert property (@(posedge mclk) disable iff (!rstN)
    (signPrimed && !swReset && (reactiveSignDir ? ($past(reactivePowerNeg) && !reactivePowerNeg)
                                : (!$past(reactivePowerNeg) && reactivePowerNeg)))
    |=> flags[SIGN_BASE + REACTIVE_SIGN_CHANGE])
    else $error("Reactive sign change not flagged");

  // Either no-load source reaches the apparent no-load bit
  a_noload_flag: assert property (@(posedge mclk) disable iff (!rstN)
    ((apparentNoLoad || irmsNoLoadEntry) && !swReset)
    |=> flags[SIGN_BASE + APPARENT_NO_LOAD])
    else $error("Apparent no-load not flagged");

  // Reactive no-load reaches its own bit
  a_reactive_noload: assert property (@(posedge mclk) disable iff (!rstN)
    (reactiveNoLoad && !swReset) |=> flags[SIGN_BASE + REACTIVE_NO_LOAD])
    else $error("Reactive no-load not flagged");

  // Current peak reaches its own bit
  a_current_peak: assert property (@(posedge mclk) disable iff (!rstN)
    (currentPeakHit && !swReset) |=> flags[LINE_BASE + CURRENT_PEAK_HIT])
    else $error("Current peak not flagged");

  // Voltage peak reaches its own bit
  a_voltage_peak: assert property (@(posedge mclk) disable iff (!rstN)
    (voltagePeakHit && !swReset) |=> flags[LINE_BASE + VOLTAGE_PEAK_HIT])
    else $error("Voltage peak not flagged");

  // Zero crossing timeout reaches its own bit
  a_cross_timeout: assert property (@(posedge mclk) disable iff (!rstN)
    (zeroCrossTimeout && !swReset) |=> flags[LINE_BASE + ZERO_CROSS_TIMEOUT])
    else $error("Zero crossing timeout not flagged");

  // Enabled first frequency pulse flag raises the request
  a_pulse_enable: assert property (@(posedge mclk) disable iff (!rstN)
    (flags[PULSE_BASE + FREQ_PULSE_ONE] && enables[PULSE_BASE + FREQ_PULSE_ONE])
    |=> meteringIrq)
    else $error("Enabled pulse flag did not raise interrupt");

  // Reserved flag and enable positions stay clear
  a_reserved_held: assert property (@(posedge mclk) disable iff (!rstN)
    ((flags & ~flagMask) == 24'h000000) && ((enables & ~enMask) == 24'h000000))
    else $error("Reserved flag or enable bit set");

endmodule
`default_nettype wire

// File: src/mif_pkg.sv
package mif_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_EN_SIGN = 8'hd9;
  localparam logic [7:0] ADDR_EN_PULSE = 8'hda;
  localparam logic [7:0] ADDR_EN_LINE = 8'hdb;
  localparam logic [7:0] ADDR_ST_SIGN = 8'hdc;
  localparam logic [7:0] ADDR_ST_PULSE = 8'hdd;
  localparam logic [7:0] ADDR_ST_LINE = 8'hde;

  // Reset values
  localparam logic [7:0] EN_SIGN_RST = 8'h00;
  localparam logic [7:0] EN_PULSE_RST = 8'h00;
  localparam logic [7:0] EN_LINE_RST = 8'h00;
  localparam logic [7:0] ST_SIGN_RST = 8'h00;
  localparam logic [7:0] ST_PULSE_RST = 8'h00;
  localparam logic [7:0] ST_LINE_RST = 8'h80;

  // Implemented bits of each register
  localparam logic [7:0] EN_SIGN_MASK = 8'h3f;
  localparam logic [7:0] EN_PULSE_MASK = 8'hff;
  localparam logic [7:0] EN_LINE_MASK = 8'h3f;
  localparam logic [7:0] ST_SIGN_MASK = 8'h3f;
  localparam logic [7:0] ST_PULSE_MASK = 8'hff;
  localparam logic [7:0] ST_LINE_MASK = 8'hbf;

  // Base of each register inside the packed 24-bit flag and enable vectors
  localparam int SIGN_BASE = 0;
  localparam int PULSE_BASE = 8;
  localparam int LINE_BASE = 16;

  // Field positions, sign and no-load register
  localparam int ACTIVE_NO_LOAD = 0;
  localparam int REACTIVE_NO_LOAD = 1;
  localparam int APPARENT_NO_LOAD = 2;
  localparam int ACTIVE_SIGN_CHANGE = 3;
  localparam int REACTIVE_SIGN_CHANGE = 4;
  localparam int FAULT_MODE_CHANGE = 5;
  localparam int RESERVED_BIT = 6;
  localparam int METERING_IRQ_SUMMARY = 7;

  // Field positions, pulse and energy register
  localparam int ACTIVE_ENERGY_HALF = 0;
  localparam int REACTIVE_ENERGY_HALF = 1;
  localparam int APPARENT_ENERGY_HALF = 2;
  localparam int ACTIVE_ENERGY_OVERFLOW = 3;
  localparam int REACTIVE_ENERGY_OVERFLOW = 4;
  localparam int APPARENT_ENERGY_OVERFLOW = 5;
  localparam int FREQ_PULSE_ONE = 6;
  localparam int FREQ_PULSE_TWO = 7;

  // Field positions, line events register
  localparam int ZERO_CROSS_SEEN = 0;
  localparam int ZERO_CROSS_TIMEOUT = 1;
  localparam int LINE_CYCLE_DONE = 2;
  localparam int VOLTAGE_PEAK_HIT = 3;
  localparam int CURRENT_PEAK_HIT = 4;
  localparam int WAVEFORM_SAMPLE_READY = 5;
  localparam int RESET_DONE = 7;

  // Number of sign change detectors
  localparam int SIGN_CHANNELS = 3;

endpackage

// File: dv/mif_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module mif_core_model (
  input wire logic mclk,
  input wire logic [7:0] sfrRdData,
  input wire logic sfrRdValid,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWrData,
  output logic sfrWrEn,
  output logic sfrRdEn
);
  // Idle bus at time zero
  initial begin
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
  end

  // One write strobe; released lines are scrambled so stale values cannot help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge mclk);
    sfrWrEn <= 1'b0;
    sfrAddr <= ~a;
    sfrWrData <= ~d;
  endtask

  // One read strobe, answer taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge mclk);
    sfrRdEn <= 1'b0;
    sfrAddr <= ~a;
    #1;
    v = sfrRdValid;
    d = sfrRdData;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import mif_pkg::*;
;
  logic mclk, nrst, swReset, sfrWrEn, sfrRdEn, sfrRdValid, meteringIrq, rdV;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rdD;
  logic [23:0] evt;
  logic [2:0] sgn, dir;
  int err_total, cmp_count;

  mif_metering_irq_flags dut_u (
    .mclk(mclk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .swReset(swReset),
    .activePowerNeg(sgn[0]), .reactivePowerNeg(sgn[1]), .faultModeAlt(sgn[2]),
    .activeSignDir(dir[0]), .reactiveSignDir(dir[1]), .faultSignDir(dir[2]),
    .apparentNoLoad(evt[2]), .irmsNoLoadEntry(evt[6]), .reactiveNoLoad(evt[1]),
    .activeNoLoad(evt[0]), .freqPulseTwo(evt[15]), .freqPulseOne(evt[14]),
    .apparentEnergyOverflow(evt[13]), .reactiveEnergyOverflow(evt[12]),
    .activeEnergyOverflow(evt[11]), .apparentEnergyHalf(evt[10]),
    .reactiveEnergyHalf(evt[9]), .activeEnergyHalf(evt[8]),
    .waveformSampleReady(evt[21]), .currentPeakHit(evt[20]), .voltagePeakHit(evt[19]),
    .lineCycleDone(evt[18]), .zeroCrossTimeout(evt[17]), .zeroCrossSeen(evt[16]),
    .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid), .meteringIrq(meteringIrq)
  );

  mif_core_model core_u (
    .mclk(mclk), .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn)
  );

  // Clock, 40 ns period
  always #20 mclk = ~mclk;

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_irq(input logic e);
    chk("meteringIrq", {7'h00, e}, {7'h00, meteringIrq});
  endtask

  // Mapped read with expected data
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    core_u.rd(a, d, v);
    chk($sformatf("valid %h", a), 8'h01, {7'h00, v});
    chk($sformatf("reg %h", a), e, d);
  endtask

  function automatic logic [7:0] staddr(input int r);
    return (r == 0) ? ADDR_ST_SIGN : (r == 1) ? ADDR_ST_PULSE : ADDR_ST_LINE;
  endfunction

  // All six registers at their reset values, no request pending
  task automatic chk_reset();
    chk_irq(1'b0);
    rdc(ADDR_EN_SIGN, EN_SIGN_RST);
    rdc(ADDR_EN_PULSE, EN_PULSE_RST);
    rdc(ADDR_EN_LINE, EN_LINE_RST);
    rdc(ADDR_ST_SIGN, ST_SIGN_RST);
    rdc(ADDR_ST_PULSE, ST_PULSE_RST);
    rdc(ADDR_ST_LINE, ST_LINE_RST);
  endtask

  // One pulse event with every enable on: flag, summary, level, clear
  task automatic pulse_check(input int i);
    int r;
    logic [7:0] m;
    r = i / 8;
    m = 8'h01 << ((i == 6) ? 2 : i % 8);
    @(posedge mclk);
    evt[i] <= 1'b1;
    @(posedge mclk);
    evt[i] <= 1'b0;
    @(posedge mclk);
    #1;
    chk_irq(1'b1);
    rdc(staddr(r), (r == 0) ? (m | 8'h80) : m);
    core_u.wr(staddr(r), ~m);
    rdc(staddr(r), 8'h00);
    chk_irq(1'b0);
  endtask

  // Sign detector: wanted edge sets the flag, opposite edge does not
  task automatic sign_check(input int ch, input logic d);
    logic [7:0] m;
    m = 8'h08 << ch;
    @(posedge mclk);
    dir[ch] <= d;
    sgn[ch] <= d;
    repeat (2) @(posedge mclk);
    core_u.wr(ADDR_ST_SIGN, 8'h00);
    @(posedge mclk);
    sgn[ch] <= ~d;
    repeat (2) @(posedge mclk);
    rdc(ADDR_ST_SIGN, m | 8'h80);
    core_u.wr(ADDR_ST_SIGN, 8'h00);
    @(posedge mclk);
    sgn[ch] <= d;
    repeat (2) @(posedge mclk);
    rdc(ADDR_ST_SIGN, 8'h00);
  endtask

  // Pending flag held back by its enable, released when enabled
  task automatic mask_check(input int i, input logic [7:0] ea, input logic [7:0] m);
    @(posedge mclk);
    evt[i] <= 1'b1;
    @(posedge mclk);
    evt[i] <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk_irq(1'b0);
    core_u.wr(ea, m);
    @(posedge mclk);
    #1;
    chk_irq(1'b1);
    core_u.wr(staddr(i / 8), ~m);
    core_u.wr(ea, 8'h00);
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    swReset = 1'b0;
    evt = 24'h000000;
    sgn = 3'h0;
    dir = 3'h0;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk_reset();
    core_u.wr(ADDR_EN_SIGN, 8'hff);
    core_u.wr(ADDR_EN_PULSE, 8'hff);
    core_u.wr(ADDR_EN_LINE, 8'hff);
    repeat (2) @(posedge mclk);
    #1;
    chk_irq(1'b0);
    rdc(ADDR_EN_SIGN, 8'h3f);
    rdc(ADDR_EN_PULSE, 8'hff);
    rdc(ADDR_EN_LINE, 8'h3f);
    core_u.wr(ADDR_ST_LINE, 8'h7f);
    rdc(ADDR_ST_LINE, 8'h00);
    core_u.rd(8'hdf, rdD, rdV);
    chk("unmapped valid", 8'h00, {7'h00, rdV});
    chk("unmapped data", 8'h00, rdD);
    for (int i = 0; i < 22; i++) begin
      if (i < 3 || i == 6 || i > 7) begin
        pulse_check(i);
      end
    end
    for (int ch = 0; ch < 3; ch++) begin
      sign_check(ch, 1'b0);
      sign_check(ch, 1'b1);
    end
    core_u.wr(ADDR_EN_SIGN, 8'h00);
    core_u.wr(ADDR_EN_PULSE, 8'h00);
    core_u.wr(ADDR_EN_LINE, 8'h00);
    mask_check(0, ADDR_EN_SIGN, 8'h01);
    mask_check(15, ADDR_EN_PULSE, 8'h80);
    mask_check(16, ADDR_EN_LINE, 8'h01);
    // Event held across a clearing write: the set must win
    @(posedge mclk);
    evt[0] <= 1'b1;
    core_u.wr(ADDR_ST_SIGN, 8'hfe);
    evt[0] <= 1'b0;
    rdc(ADDR_ST_SIGN, 8'h01);
    core_u.wr(ADDR_EN_PULSE, 8'hff);
    @(posedge mclk);
    evt[15] <= 1'b1;
    swReset <= 1'b1;
    @(posedge mclk);
    evt[15] <= 1'b0;
    swReset <= 1'b0;
    @(posedge mclk);
    #1;
    chk_reset();
    print_verdict();
  end

  // Watchdog, far beyond the expected run length
  initial begin
    #(40 * 20000);
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
